/* design/ipps_arbiter.sv */
// Purpose: Picks the highest-ranking pending source for each of the two priority levels
// Assumes: Lower source index wins inside a level
// Notes:   Pure combinational lookup, no state
`timescale 1ns/1ps
module ipps_arbiter
  import ipps_pkg::*;
#(
  parameter int N = IPPS_NSRC
) (
  input  wire logic [N-1:0]         req,
  input  wire logic [N-1:0]         prio,
  output logic                      hi_any,
  output logic [$clog2(N)-1:0]      hi_idx,
  output logic                      lo_any,
  output logic [$clog2(N)-1:0]      lo_idx
);

  // ----------------------------------------------------------------
  // Fixed-order scan, last assignment is from the lowest index
  // ----------------------------------------------------------------
  always_comb begin
    hi_any = 1'b0;
    lo_any = 1'b0;
    hi_idx = '0;
    lo_idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i] && prio[i]) begin
        hi_any = 1'b1;
        hi_idx = i[$clog2(N)-1:0];
      end
      if (req[i] && !prio[i]) begin
        lo_any = 1'b1;
        lo_idx = i[$clog2(N)-1:0];
      end
    end
  end

endmodule // ipps_arbiter

/* design/ipps_pkg.sv */
// Purpose: Constants and types shared by the interrupt priority and page stack block
// Assumes: 8-bit special register bus, six classic interrupt sources
// Notes:   Offsets are byte addresses in the special register space
package ipps_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] IPPS_PAGE_CONTROL_ADDR = 8'h96;
  localparam logic [7:0] IPPS_PRIORITY_ADDR     = 8'hB8;
  localparam logic [7:0] IPPS_PAGE_CONTROL_RST  = 8'h01;
  localparam logic [7:0] IPPS_PRIORITY_RST      = 8'hC0;
  localparam logic [1:0] IPPS_PRIO_UNUSED_VAL   = 2'h3;
  localparam int         IPPS_APEN_BIT          = 0;
  localparam int         IPPS_NSRC              = 6;

  // Page that holds the core's own registers; pages reset here
  localparam logic [7:0] IPPS_PAGE_RST          = 8'h00;

  // Nesting level of the core
  typedef enum logic [1:0] {
    IPPS_LVL_IDLE,
    IPPS_LVL_LOW,
    IPPS_LVL_HIGH
  } ipps_level_t;

endpackage : ipps_pkg

/* design/ipps_top.sv */
// Purpose: Interrupt priority register, nesting control and register page stack
// Assumes: Core pulses VECTOR_ACK when it takes the offered vector and RETI_PULSE
//          when a handler returns; register bus is the core's special register port
// Notes:   One nesting level per priority. A return with nothing running is
//          harmless, but it still pops the page stack while paging is on.
//          Hardware push and pop win over a same-cycle direct page write.
//          Software must restore the bottom entry itself if it needs it.
//          Notes on behaviour below
//
// Notes on behaviour
// - High priority request preempts a running low handler
// - Auto paging loads source page on vector
// - Old current page pushed into stack middle
// - Old middle entry pushed into stack bottom
// - Bottom entry overwritten on push, no warning
// - Priority bits 7 and 6 read 11
// - Priority bits 5..0 select per-source level
// - Unassigned addresses are reserved, read zero
`timescale 1ns/1ps
module ipps_top
  import ipps_pkg::*;
#(
  parameter int         N_SRC  = IPPS_NSRC,
  // Page of each source, source 0 in the low byte
  parameter logic [47:0] SRC_PAGES = 48'h00_00_00_00_00_00
) (
  input  wire logic              CORE_CLK,
  input  wire logic              RESET,
  input  wire logic [7:0]        REG_ADDR,
  input  wire logic              REG_WR,
  input  wire logic [7:0]        REG_WDATA,
  input  wire logic              REG_RD,
  input  wire logic              PAGE_WR,
  input  wire logic [1:0]        PAGE_SEL,
  input  wire logic [N_SRC-1:0]  IRQ_PENDING,
  input  wire logic              VECTOR_ACK,
  input  wire logic              RETI_PULSE,
  output logic [7:0]             REG_RDATA,
  output logic                   VECTOR_REQ,
  output logic [2:0]             VECTOR_IDX,
  output logic                   VECTOR_HIGH,
  output logic [7:0]             CURRENT_PAGE,
  output logic [7:0]             STACK_MIDDLE,
  output logic [7:0]             STACK_BOTTOM
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [5:0]  prio_q, prio_d;
  logic        apen_q, apen_d;
  logic [7:0]  cur_q, cur_d;             // Current page selector
  logic [7:0]  mid_q, mid_d;             // Page stack middle entry
  logic [7:0]  bot_q, bot_d;             // Page stack bottom entry, lost on push
  ipps_level_t lvl_q, lvl_d;
  logic        low_nest_q, low_nest_d;   // Low handler was preempted
  logic [7:0]  rdata_q, rdata_d;
  logic        vreq_q, vreq_d;           // Vector offered to the core
  logic        vhigh_q, vhigh_d;         // Offered vector is high priority
  logic [2:0]  vidx_q, vidx_d;

  logic        hi_any, lo_any;
  logic [2:0]  hi_idx, lo_idx;
  logic        take_vec;                 // Core takes the vector standing now

  // Page of a source, looked up in the per-source page table
  function automatic logic [7:0] src_page(input logic [2:0] idx);
    src_page = SRC_PAGES[idx*8 +: 8];
  endfunction

  // Register decode, shared by the write and read paths so both agree
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
    reg_hit = (addr == target);
  endfunction

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  // One scan per level; the level that wins is chosen in the next-state logic
  ipps_arbiter #(.N(N_SRC)) u_arb (
    .req    (IRQ_PENDING),
    .prio   (prio_q),
    .hi_any (hi_any),
    .hi_idx (hi_idx),
    .lo_any (lo_any),
    .lo_idx (lo_idx)
  );

  // An acknowledge only counts while an offer stands; a stray one is ignored
  assign take_vec = VECTOR_ACK && vreq_q;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Hold every register except the offer and read data, which default to zero, unless an event below moves it
  always_comb begin
    prio_d     = prio_q;
    apen_d     = apen_q;
    cur_d      = cur_q;
    mid_d      = mid_q;
    bot_d      = bot_q;
    lvl_d      = lvl_q;
    low_nest_d = low_nest_q;
    vreq_d     = 1'b0;
    vidx_d     = vidx_q;
    vhigh_d    = vhigh_q;
    rdata_d    = 8'h00;

    // Software writes to registers; page stack entries via direct port
    if (REG_WR) begin
      // Bits 7 and 6 of the priority register have no storage behind them
      if (reg_hit(REG_ADDR, IPPS_PRIORITY_ADDR)) begin
        prio_d = REG_WDATA[5:0];
      end
      if (reg_hit(REG_ADDR, IPPS_PAGE_CONTROL_ADDR)) begin
        apen_d = REG_WDATA[IPPS_APEN_BIT];
      end
    end
    if (PAGE_WR) begin
      unique case (PAGE_SEL)
        2'h0:       cur_d = REG_WDATA;
        2'h1:       mid_d = REG_WDATA;
        2'h2, 2'h3: bot_d = REG_WDATA;
      endcase
    end

    // Reads; unassigned addresses answer zero
    if (REG_RD) begin
      if (reg_hit(REG_ADDR, IPPS_PRIORITY_ADDR))
        rdata_d = {IPPS_PRIO_UNUSED_VAL, prio_q};
      else if (reg_hit(REG_ADDR, IPPS_PAGE_CONTROL_ADDR))
        rdata_d = {7'h00, apen_q};
      else
        rdata_d = 8'h00;
    end

    // Offer a vector: high may interrupt idle or low, low only idle.
    // The offer is rebuilt every cycle from the pending lines, so a source
    // that drops its request before the core acknowledges simply vanishes;
    // the cost is one cycle of latency from request to offer.
    if (hi_any && lvl_q != IPPS_LVL_HIGH) begin
      vreq_d  = 1'b1;
      vidx_d  = hi_idx;
      vhigh_d = 1'b1;
    end else if (lo_any && lvl_q == IPPS_LVL_IDLE) begin
      vreq_d  = 1'b1;
      vidx_d  = lo_idx;
      vhigh_d = 1'b0;
    end

    // Entry; hardware push wins over a same-cycle software page write
    if (take_vec) begin
      if (vhigh_q) begin
        low_nest_d = (lvl_q == IPPS_LVL_LOW);
        lvl_d      = IPPS_LVL_HIGH;
      end else begin
        lvl_d = IPPS_LVL_LOW;
      end
      vreq_d = 1'b0;
      if (apen_q) begin
        cur_d = src_page(vidx_q);
        mid_d = cur_q;
        bot_d = mid_q;
      end
    end else if (RETI_PULSE) begin
      // Return unwinds one nesting level
      unique case (lvl_q)
        IPPS_LVL_HIGH: begin
          lvl_d      = low_nest_q ? IPPS_LVL_LOW : IPPS_LVL_IDLE;
          low_nest_d = 1'b0;
        end
        IPPS_LVL_LOW:  lvl_d = IPPS_LVL_IDLE;
        IPPS_LVL_IDLE: lvl_d = IPPS_LVL_IDLE;
        default:       lvl_d = IPPS_LVL_IDLE;   // Unused two-bit code recovers
      endcase
      if (apen_q) begin
        cur_d = mid_q;
        mid_d = bot_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Synchronous reset; every register runs on every edge
  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      prio_q     <= IPPS_PRIORITY_RST[5:0];
      apen_q     <= IPPS_PAGE_CONTROL_RST[IPPS_APEN_BIT];
      cur_q      <= IPPS_PAGE_RST;
      mid_q      <= IPPS_PAGE_RST;
      bot_q      <= IPPS_PAGE_RST;
      lvl_q      <= IPPS_LVL_IDLE;
      low_nest_q <= 1'b0;
      rdata_q    <= 8'h00;
      vreq_q     <= 1'b0;
      vidx_q     <= 3'h0;
      vhigh_q    <= 1'b0;
    end else begin
      prio_q     <= prio_d;
      apen_q     <= apen_d;
      cur_q      <= cur_d;
      mid_q      <= mid_d;
      bot_q      <= bot_d;
      lvl_q      <= lvl_d;
      low_nest_q <= low_nest_d;
      rdata_q    <= rdata_d;
      vreq_q     <= vreq_d;
      vidx_q     <= vidx_d;
      vhigh_q    <= vhigh_d;
    end
  end

  // Outputs straight from flops
  assign REG_RDATA    = rdata_q;
  assign VECTOR_REQ   = vreq_q;
  assign VECTOR_IDX   = vidx_q;
  assign VECTOR_HIGH  = vhigh_q;
  assign CURRENT_PAGE = cur_q;
  assign STACK_MIDDLE = mid_q;
  assign STACK_BOTTOM = bot_q;

endmodule // ipps_top

/* tb/ipps_core_model.sv */
// Purpose: Core stand-in that takes offered vectors
// Assumes: Takes a vector one cycle after seeing the request
// Notes:   Low go stalls the core as long as the bench wishes
`timescale 1ns/1ps
module ipps_core_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic go,
  input  wire logic req,
  output logic      ack
);
  // Registered pulse, so ack never stands two cycles on one request
  always_ff @(posedge clk) ack <= !rst && go && req && !ack;
endmodule // ipps_core_model

/* tb/ipps_top_monitor.sv */
// Purpose: Port checker for the priority and page stack block
// Assumes: Shadows page control and priority writes seen at the ports
// Notes:   Bound to every ipps_top instance
`timescale 1ns/1ps
module ipps_top_monitor
  import ipps_pkg::*;
#(
  parameter int          N_SRC     = IPPS_NSRC,
  parameter logic [47:0] SRC_PAGES = 48'h0
) (
  input  wire logic       CORE_CLK,
  input  wire logic       RESET,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  input  wire logic       PAGE_WR,
  input  wire logic       VECTOR_ACK,
  input  wire logic       RETI_PULSE,
  input  wire logic       VECTOR_REQ,
  input  wire logic       VECTOR_HIGH,
  input  wire logic [2:0] VECTOR_IDX,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic [7:0] REG_RDATA,
  input  wire logic [7:0] CURRENT_PAGE,
  input  wire logic [7:0] STACK_MIDDLE,
  input  wire logic [7:0] STACK_BOTTOM
);
  logic       en_q, en_d;
  logic [5:0] pr_q, pr_d;
  logic [7:0] pg_q;
  wire        tk = VECTOR_ACK && VECTOR_REQ;
  // Shadow copies, updated on the same edge as the design's registers
  always_comb begin
    en_d = en_q;
    pr_d = pr_q;
    if (REG_WR && REG_ADDR == IPPS_PAGE_CONTROL_ADDR) en_d = REG_WDATA[IPPS_APEN_BIT];
    if (REG_WR && REG_ADDR == IPPS_PRIORITY_ADDR) pr_d = REG_WDATA[5:0];
  end
  always_ff @(posedge CORE_CLK) begin
    en_q <= RESET ? IPPS_PAGE_CONTROL_RST[IPPS_APEN_BIT] : en_d;
    pr_q <= RESET ? IPPS_PRIORITY_RST[5:0] : pr_d;
    pg_q <= SRC_PAGES[VECTOR_IDX*8 +: 8];
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  AST_PAGE_LOAD: assert property (tk && en_q |=> CURRENT_PAGE == pg_q)
    else $error("source page not loaded");
  AST_PUSH_MID: assert property (tk && en_q |=> STACK_MIDDLE == $past(CURRENT_PAGE))
    else $error("middle entry not pushed");
  AST_PUSH_BOT: assert property (tk && en_q |=> STACK_BOTTOM == $past(STACK_MIDDLE))
    else $error("bottom entry not pushed");
  AST_NO_PAGE: assert property (tk && !en_q && !PAGE_WR |=> $stable(CURRENT_PAGE))
    else $error("page moved while disabled");
  AST_POP: assert property (RETI_PULSE && !tk && en_q |=>
    CURRENT_PAGE == $past(STACK_MIDDLE) && STACK_MIDDLE == $past(STACK_BOTTOM))
    else $error("stack not popped");
  AST_TOP_BITS: assert property (REG_RD && REG_ADDR == IPPS_PRIORITY_ADDR |=>
    REG_RDATA[7:6] == IPPS_PRIO_UNUSED_VAL) else $error("priority top bits wrong");
  AST_RSVD: assert property (REG_RD && REG_ADDR != IPPS_PRIORITY_ADDR &&
    REG_ADDR != IPPS_PAGE_CONTROL_ADDR |=> REG_RDATA == 8'h00) else $error("reserved read");
  AST_LEVEL: assert property (VECTOR_REQ && $stable(pr_q) |->
    VECTOR_HIGH == pr_q[VECTOR_IDX]) else $error("offered level wrong");
endmodule // ipps_top_monitor
bind ipps_top ipps_top_monitor #(.N_SRC(N_SRC), .SRC_PAGES(SRC_PAGES)) u_ipps_top_monitor (
  .CORE_CLK, .RESET, .REG_WR, .REG_RD, .PAGE_WR, .VECTOR_ACK, .RETI_PULSE, .VECTOR_REQ,
  .VECTOR_HIGH, .VECTOR_IDX, .REG_ADDR, .REG_WDATA, .REG_RDATA, .CURRENT_PAGE,
  .STACK_MIDDLE, .STACK_BOTTOM);

/* tb/ipps_top_test.sv */
// Purpose: Register, nesting and page stack tests
// Assumes: Source i lives on page 0x20+i
// Notes:   Inputs change by non-blocking assignment at the rising edge
`timescale 1ns/1ps
module ipps_top_test;
  import ipps_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, pw = 0, reti = 0, go = 1, ack, req, hi;
  logic [7:0] addr = 0, wd = 0, rdata, cur, mid, bot;
  logic [5:0] irq = 0;
  logic [2:0] idx;
  logic [1:0] sel = 0;
  int num_errors = 0, compares = 0;
  always #2.5 clk = ~clk;
  ipps_top #(.SRC_PAGES(48'h25_24_23_22_21_20)) u_ipps_top (.CORE_CLK(clk), .RESET(rst),
    .REG_ADDR(addr), .REG_WR(wr), .REG_WDATA(wd), .REG_RD(rd), .PAGE_WR(pw), .PAGE_SEL(sel),
    .IRQ_PENDING(irq), .VECTOR_ACK(ack), .RETI_PULSE(reti), .REG_RDATA(rdata),
    .VECTOR_REQ(req), .VECTOR_IDX(idx), .VECTOR_HIGH(hi), .CURRENT_PAGE(cur),
    .STACK_MIDDLE(mid), .STACK_BOTTOM(bot));
  ipps_core_model u_ipps_core_model (.clk(clk), .rst(rst), .go(go), .req(req), .ack(ack));
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wreg(logic [7:0] a, logic [7:0] d, logic p);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= !p;
    pw <= p;
    sel <= a[1:0];
    @(posedge clk);
    wr <= 0;
    pw <= 0;
  endtask
  // Read data stands one cycle after the strobe edge
  task automatic rreg(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    addr <= a; rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk("rdata", e, rdata);
  endtask
  task automatic pages(logic [7:0] c, logic [7:0] m, logic [7:0] b);
    @(posedge clk);
    chk("cur", c, cur);
    chk("mid", m, mid);
    chk("bot", b, bot);
    // Nothing pending here, and a taken offer must not linger
    chk("req", 8'h00, {7'h0, req});
  endtask
  // Raise one source; at the taking edge the offered vector is checked
  task automatic take(int i, logic h);
    int n;
    @(posedge clk);
    irq[i] <= 1;
    n = 0;
    do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
    irq[i] <= 0;
    chk("ack", 8'h01, {7'h0, ack});
    chk("idx", i[7:0], {5'h0, idx});
    chk("hi", {7'h0, h}, {7'h0, hi});
  endtask
  task automatic pop();
    @(posedge clk);
    reti <= 1;
    @(posedge clk);
    reti <= 0;
  endtask
  task automatic complete_run();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    // Scenarios need under 200 cycles; 4000 leaves room yet still catches a hang
    #20000 num_errors++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    rreg(IPPS_PAGE_CONTROL_ADDR, IPPS_PAGE_CONTROL_RST);
    rreg(IPPS_PRIORITY_ADDR, IPPS_PRIORITY_RST);
    wreg(IPPS_PRIORITY_ADDR, 8'h15, 0);
    rreg(IPPS_PRIORITY_ADDR, 8'hD5);
    rreg(8'h50, 8'h00);
    $display("register test done");
    wreg(8'h00, 8'h11, 1);
    wreg(8'h01, 8'h12, 1);
    wreg(8'h02, 8'h13, 1);
    wreg(IPPS_PRIORITY_ADDR, 8'h20, 0);
    take(0, 0);
    pages(8'h20, 8'h11, 8'h12);
    take(5, 1);
    pages(8'h25, 8'h20, 8'h11);
    pop();
    pages(8'h20, 8'h11, 8'h11);
    pop();
    pages(8'h11, 8'h11, 8'h11);
    $display("nesting test done");
    wreg(IPPS_PAGE_CONTROL_ADDR, 8'h00, 0);
    take(1, 0);
    pages(8'h11, 8'h11, 8'h11);
    $display("paging off test done");
    // A low request is held back while a low handler runs; once offered,
    // the offer must still stand three cycles after the return, with the core still stalled
    go <= 0;
    irq[3] <= 1;
    repeat (3) @(posedge clk);
    chk("req", 8'h00, {7'h0, req});
    pop();
    repeat (3) @(posedge clk);
    chk("req", 8'h01, {7'h0, req});
    chk("idx", 8'h03, {5'h0, idx});
    chk("hi", 8'h00, {7'h0, hi});
    go <= 1;
    take(3, 0);
    pages(8'h11, 8'h11, 8'h11);
    $display("stall test done");
    complete_run();
  end
endmodule // ipps_top_test
